// file: rtl/scor_regs.sv
// Sink configuration override register bank with host port and mirror outputs
// Function
// - First-pattern override bit 31 selects programmed score
// - Later-pattern override bit 31 selects programmed score
// - Allocation register mirrors slot count, start, ID
// - CRC control bit 5 enables external CRC
// - Video descriptor bit 0 announces local descriptor
// - Audio descriptor bit 0 announces local descriptor
// - Remote byte exposed to transmitter
// - Service bit 4 write flags down reply
// - Service bit 1 reflects sink-specific flag
// - Writing 0x1 sets remote-control-pending flag
// - Writing zero to service register changes nothing
// - Service reads return live vector state
// - Video unsupported bit 0 informs transmitter
// - Audio unsupported bit 0 informs transmitter
// - Legal rate codes 0x6, 0xA, 0x14, 0x1E
// - Override control 0x1 opens capability writes
`timescale 1ns/1ps
`default_nettype none
module scor_regs
   import scor_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Host register port
   input wire logic [SCOR_AW-1:0] host_addr_in,
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire logic [SCOR_DW-1:0] host_wdata_in,
   output logic [SCOR_DW-1:0] host_rdata_out,
   output logic host_rvalid_out,
   // Training score path
   input wire logic [SCOR_TP1_W-1:0] tp1_measured_in,
   input wire logic [SCOR_TP23_W-1:0] tp23_measured_in,
   output logic [SCOR_TP1_W-1:0] tp1_score_out,
   output logic [SCOR_TP23_W-1:0] tp23_score_out,
   // Sink configuration space mirror inputs
   input wire logic [SCOR_ALLOC_FW-1:0] slot_count_in,
   input wire logic [SCOR_ALLOC_FW-1:0] slot_start_in,
   input wire logic [SCOR_ALLOC_FW-1:0] payload_id_in,
   input wire logic sink_specific_interrupt_flag_in,
   input wire logic pending_clear_in, // Transmitter cleared remote-control-pending
   input wire logic down_reply_clear_in, // Transmitter cleared down reply ready
   input wire logic [SCOR_RATE_W-1:0] link_rate_setting_in, // Rate written by transmitter
   // CRC outputs
   output logic crc_enable_out,
   output logic [SCOR_CRC_CNT_W-1:0] crc_change_count_out,
   output logic [SCOR_DW-1:0] crc_red_out,
   output logic [SCOR_DW-1:0] crc_green_out,
   output logic [SCOR_DW-1:0] crc_blue_out,
   // Sink configuration space mirror outputs
   output logic video_local_descriptor_flag_out,
   output logic audio_local_descriptor_flag_out,
   output logic [SCOR_BYTE_W-1:0] remote_byte_out,
   output logic remote_control_pending_out,
   output logic down_reply_ready_out,
   output logic video_not_supported_out,
   output logic audio_not_supported_out,
   output logic capability_write_en_out,
   output logic [SCOR_RATE_W-1:0] link_rate_setting_out
);
   // Stored register contents
   scor_word_t tp1_ovr_r, tp1_ovr_nxt; // Score override for first pattern
   scor_word_t tp23_ovr_r, tp23_ovr_nxt; // Score override for later patterns
   logic crc_en_r, crc_en_nxt;
   logic [SCOR_CRC_CNT_W-1:0] crc_cnt_r, crc_cnt_nxt;
   scor_word_t crc_red_r, crc_red_nxt;
   scor_word_t crc_green_r, crc_green_nxt;
   scor_word_t crc_blue_r, crc_blue_nxt;
   logic vid_desc_r, vid_desc_nxt;
   logic aud_desc_r, aud_desc_nxt;
   logic [SCOR_BYTE_W-1:0] remote_r, remote_nxt;
   logic pend_r, pend_nxt; // Remote-control-pending flag of the vector
   logic down_r, down_nxt; // Down reply ready flag of the vector
   logic vid_unsup_r, vid_unsup_nxt;
   logic aud_unsup_r, aud_unsup_nxt;
   logic [SCOR_RATE_W-1:0] rate_ovr_r, rate_ovr_nxt; // Programmed rate code
   logic ovr_ctrl_r, ovr_ctrl_nxt; // Capability write access enable
   logic [SCOR_RATE_W-1:0] rate_eff_r, rate_eff_nxt; // Rate seen by the transmitter
   scor_word_t rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   // Write strobe for one decoded offset
   function automatic logic hit(input scor_addr_t a, input scor_addr_t ofs, input logic stb);
      hit = stb && (a == ofs);
   endfunction
   // Only the four published rate codes are accepted
   function automatic logic rate_legal(input logic [SCOR_RATE_W-1:0] code);
      rate_legal = (code == SCOR_RATE_1G62) || (code == SCOR_RATE_2G70) ||
                   (code == SCOR_RATE_5G40) || (code == SCOR_RATE_8G10);
   endfunction

   // Score selectors; each registers its own result
   scor_score_select #(.W(SCOR_TP1_W)) u_tp1_sel (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .override_en_in(tp1_ovr_r[SCOR_SCORE_EN_BIT]),
      .override_val_in(tp1_ovr_r[SCOR_TP1_W-1:0]),
      .measured_in(tp1_measured_in),
      .score_out(tp1_score_out)
   );

   scor_score_select #(.W(SCOR_TP23_W)) u_tp23_sel (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .override_en_in(tp23_ovr_r[SCOR_SCORE_EN_BIT]),
      .override_val_in(tp23_ovr_r[SCOR_TP23_W-1:0]),
      .measured_in(tp23_measured_in),
      .score_out(tp23_score_out)
   );

   // Next values for the writable registers; the vector flags follow below
   always_comb begin
      tp1_ovr_nxt = tp1_ovr_r;
      tp23_ovr_nxt = tp23_ovr_r;
      crc_en_nxt = crc_en_r;
      crc_cnt_nxt = crc_cnt_r;
      crc_red_nxt = crc_red_r;
      crc_green_nxt = crc_green_r;
      crc_blue_nxt = crc_blue_r;
      vid_desc_nxt = vid_desc_r;
      aud_desc_nxt = aud_desc_r;
      remote_nxt = remote_r;
      vid_unsup_nxt = vid_unsup_r;
      aud_unsup_nxt = aud_unsup_r;
      rate_ovr_nxt = rate_ovr_r;
      ovr_ctrl_nxt = ovr_ctrl_r;
      // Unused score bits are dropped so reads show only real fields
      if (hit(host_addr_in, SCOR_OFS_TP1_SCORE, host_wr_in)) begin
         tp1_ovr_nxt = SCOR_WORD_RST;
         tp1_ovr_nxt[SCOR_SCORE_EN_BIT] = host_wdata_in[SCOR_SCORE_EN_BIT];
         tp1_ovr_nxt[SCOR_TP1_W-1:0] = host_wdata_in[SCOR_TP1_W-1:0];
      end
      if (hit(host_addr_in, SCOR_OFS_TP23_SCORE, host_wr_in)) begin
         tp23_ovr_nxt = SCOR_WORD_RST;
         tp23_ovr_nxt[SCOR_SCORE_EN_BIT] = host_wdata_in[SCOR_SCORE_EN_BIT];
         tp23_ovr_nxt[SCOR_TP23_W-1:0] = host_wdata_in[SCOR_TP23_W-1:0];
      end
      if (hit(host_addr_in, SCOR_OFS_CRC_CONTROL, host_wr_in)) begin
         crc_en_nxt = host_wdata_in[SCOR_CRC_EN_BIT];
         crc_cnt_nxt = host_wdata_in[SCOR_CRC_CNT_W-1:0];
      end
      // Colour values are held whole, as software computed them
      if (hit(host_addr_in, SCOR_OFS_CRC_RED, host_wr_in)) begin
         crc_red_nxt = host_wdata_in;
      end
      if (hit(host_addr_in, SCOR_OFS_CRC_GREEN, host_wr_in)) begin
         crc_green_nxt = host_wdata_in;
      end
      if (hit(host_addr_in, SCOR_OFS_CRC_BLUE, host_wr_in)) begin
         crc_blue_nxt = host_wdata_in;
      end
      if (hit(host_addr_in, SCOR_OFS_VIDEO_DESC, host_wr_in)) begin
         vid_desc_nxt = host_wdata_in[SCOR_FLAG_BIT];
      end
      if (hit(host_addr_in, SCOR_OFS_AUDIO_DESC, host_wr_in)) begin
         aud_desc_nxt = host_wdata_in[SCOR_FLAG_BIT];
      end
      if (hit(host_addr_in, SCOR_OFS_REMOTE_BYTE, host_wr_in)) begin
         remote_nxt = host_wdata_in[SCOR_BYTE_W-1:0];
      end
      if (hit(host_addr_in, SCOR_OFS_VIDEO_UNSUP, host_wr_in)) begin
         vid_unsup_nxt = host_wdata_in[SCOR_FLAG_BIT];
      end
      if (hit(host_addr_in, SCOR_OFS_AUDIO_UNSUP, host_wr_in)) begin
         aud_unsup_nxt = host_wdata_in[SCOR_FLAG_BIT];
      end
      if (hit(host_addr_in, SCOR_OFS_LINK_RATE, host_wr_in)) begin
         rate_ovr_nxt = host_wdata_in[SCOR_RATE_W-1:0];
      end
      // Only the exact value one opens access; anything else closes it
      if (hit(host_addr_in, SCOR_OFS_OVERRIDE_CTRL, host_wr_in)) begin
         ovr_ctrl_nxt = (host_wdata_in == SCOR_OVR_ENABLE);
      end
   end

   // Next values of the service vector flags; a set beats a same-cycle clear
   always_comb begin
      pend_nxt = pend_r;
      down_nxt = down_r;
      if (pending_clear_in) begin
         pend_nxt = 1'b0;
      end
      if (down_reply_clear_in) begin
         down_nxt = 1'b0;
      end
      // Ones set flags, zeros leave them alone
      if (hit(host_addr_in, SCOR_OFS_SERVICE_IRQ, host_wr_in)) begin
         if (host_wdata_in[SCOR_SVC_PEND_BIT]) begin
            pend_nxt = 1'b1;
         end
         if (host_wdata_in[SCOR_SVC_DOWN_BIT]) begin
            down_nxt = 1'b1;
         end
      end
   end

   // Rate the transmitter sees; an illegal code falls back to its own value
   always_comb begin
      if (ovr_ctrl_r && rate_legal(rate_ovr_r)) begin
         rate_eff_nxt = rate_ovr_r;
      end else begin
         rate_eff_nxt = link_rate_setting_in;
      end
   end

   // Read mux; one cycle latency, unmapped offsets read zero
   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = host_rd_in;
      if (host_rd_in) begin
         rdata_nxt = SCOR_WORD_RST;
         unique case (host_addr_in)
            SCOR_OFS_TP1_SCORE: begin
               rdata_nxt = tp1_ovr_r;
            end
            SCOR_OFS_TP23_SCORE: begin
               rdata_nxt = tp23_ovr_r;
            end
            SCOR_OFS_PAYLOAD_ALLOC: begin
               rdata_nxt[SCOR_SLOT_CNT_LSB +: SCOR_ALLOC_FW] = slot_count_in;
               rdata_nxt[SCOR_SLOT_START_LSB +: SCOR_ALLOC_FW] = slot_start_in;
               rdata_nxt[SCOR_PAYLOAD_ID_LSB +: SCOR_ALLOC_FW] = payload_id_in;
            end
            SCOR_OFS_CRC_CONTROL: begin
               rdata_nxt[SCOR_CRC_EN_BIT] = crc_en_r;
               rdata_nxt[SCOR_CRC_CNT_W-1:0] = crc_cnt_r;
            end
            SCOR_OFS_CRC_RED: begin
               rdata_nxt = crc_red_r;
            end
            SCOR_OFS_CRC_GREEN: begin
               rdata_nxt = crc_green_r;
            end
            SCOR_OFS_CRC_BLUE: begin
               rdata_nxt = crc_blue_r;
            end
            SCOR_OFS_VIDEO_DESC: begin
               rdata_nxt[SCOR_FLAG_BIT] = vid_desc_r;
            end
            SCOR_OFS_AUDIO_DESC: begin
               rdata_nxt[SCOR_FLAG_BIT] = aud_desc_r;
            end
            SCOR_OFS_REMOTE_BYTE: begin
               rdata_nxt[SCOR_BYTE_W-1:0] = remote_r;
            end
            // Live vector state, not the last written word
            SCOR_OFS_SERVICE_IRQ: begin
               rdata_nxt[SCOR_SVC_PEND_BIT] = pend_r;
               rdata_nxt[SCOR_SVC_SINK_BIT] = sink_specific_interrupt_flag_in;
               rdata_nxt[SCOR_SVC_DOWN_BIT] = down_r;
            end
            SCOR_OFS_VIDEO_UNSUP: begin
               rdata_nxt[SCOR_FLAG_BIT] = vid_unsup_r;
            end
            SCOR_OFS_AUDIO_UNSUP: begin
               rdata_nxt[SCOR_FLAG_BIT] = aud_unsup_r;
            end
            SCOR_OFS_LINK_RATE: begin
               rdata_nxt[SCOR_RATE_W-1:0] = rate_ovr_r;
            end
            SCOR_OFS_OVERRIDE_CTRL: begin
               rdata_nxt[SCOR_FLAG_BIT] = ovr_ctrl_r;
            end
            default: begin
               rdata_nxt = SCOR_WORD_RST;
            end
         endcase
      end
   end

   // Register stage for every piece of state
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         tp1_ovr_r <= SCOR_WORD_RST;
         tp23_ovr_r <= SCOR_WORD_RST;
         crc_en_r <= 1'b0;
         crc_cnt_r <= '0;
         crc_red_r <= SCOR_WORD_RST;
         crc_green_r <= SCOR_WORD_RST;
         crc_blue_r <= SCOR_WORD_RST;
         vid_desc_r <= 1'b0;
         aud_desc_r <= 1'b0;
         remote_r <= '0;
         pend_r <= 1'b0;
         down_r <= 1'b0;
         vid_unsup_r <= 1'b0;
         aud_unsup_r <= 1'b0;
         rate_ovr_r <= SCOR_RATE_RST;
         ovr_ctrl_r <= 1'b0;
         rate_eff_r <= SCOR_RATE_RST;
         rdata_r <= SCOR_WORD_RST;
         rvalid_r <= 1'b0;
      end else begin
         tp1_ovr_r <= tp1_ovr_nxt;
         tp23_ovr_r <= tp23_ovr_nxt;
         crc_en_r <= crc_en_nxt;
         crc_cnt_r <= crc_cnt_nxt;
         crc_red_r <= crc_red_nxt;
         crc_green_r <= crc_green_nxt;
         crc_blue_r <= crc_blue_nxt;
         vid_desc_r <= vid_desc_nxt;
         aud_desc_r <= aud_desc_nxt;
         remote_r <= remote_nxt;
         pend_r <= pend_nxt;
         down_r <= down_nxt;
         vid_unsup_r <= vid_unsup_nxt;
         aud_unsup_r <= aud_unsup_nxt;
         rate_ovr_r <= rate_ovr_nxt;
         ovr_ctrl_r <= ovr_ctrl_nxt;
         rate_eff_r <= rate_eff_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end
   // Outputs straight from flops
   assign host_rdata_out = rdata_r;
   assign host_rvalid_out = rvalid_r;
   assign crc_enable_out = crc_en_r;
   assign crc_change_count_out = crc_cnt_r;
   assign crc_red_out = crc_red_r;
   assign crc_green_out = crc_green_r;
   assign crc_blue_out = crc_blue_r;
   assign video_local_descriptor_flag_out = vid_desc_r;
   assign audio_local_descriptor_flag_out = aud_desc_r;
   assign remote_byte_out = remote_r;
   assign remote_control_pending_out = pend_r;
   assign down_reply_ready_out = down_r;
   assign video_not_supported_out = vid_unsup_r;
   assign audio_not_supported_out = aud_unsup_r;
   assign capability_write_en_out = ovr_ctrl_r;
   assign link_rate_setting_out = rate_eff_r;
endmodule
`default_nettype wire

// file: include/scor_pkg.sv
// Package: offsets, field positions, reset values and encodings of the override bank
`default_nettype none
package scor_pkg;
   // Host port widths
   localparam int unsigned SCOR_AW = 8;
   localparam int unsigned SCOR_DW = 32;
   typedef logic [SCOR_AW-1:0] scor_addr_t;
   typedef logic [SCOR_DW-1:0] scor_word_t;

   // Register byte offsets
   localparam scor_addr_t SCOR_OFS_TP1_SCORE = 8'h64;
   localparam scor_addr_t SCOR_OFS_TP23_SCORE = 8'h68;
   localparam scor_addr_t SCOR_OFS_PAYLOAD_ALLOC = 8'h6C;
   localparam scor_addr_t SCOR_OFS_CRC_CONTROL = 8'h74;
   localparam scor_addr_t SCOR_OFS_CRC_RED = 8'h78;
   localparam scor_addr_t SCOR_OFS_CRC_GREEN = 8'h7C;
   localparam scor_addr_t SCOR_OFS_CRC_BLUE = 8'h80;
   localparam scor_addr_t SCOR_OFS_VIDEO_DESC = 8'h84;
   localparam scor_addr_t SCOR_OFS_AUDIO_DESC = 8'h88;
   localparam scor_addr_t SCOR_OFS_REMOTE_BYTE = 8'h8C;
   localparam scor_addr_t SCOR_OFS_SERVICE_IRQ = 8'h90;
   localparam scor_addr_t SCOR_OFS_VIDEO_UNSUP = 8'h94;
   localparam scor_addr_t SCOR_OFS_AUDIO_UNSUP = 8'h98;
   localparam scor_addr_t SCOR_OFS_LINK_RATE = 8'h9C;
   localparam scor_addr_t SCOR_OFS_OVERRIDE_CTRL = 8'hB8;

   // Score override fields
   localparam int unsigned SCOR_SCORE_EN_BIT = 31;
   localparam int unsigned SCOR_TP1_W = 15;
   localparam int unsigned SCOR_TP23_W = 13;

   // Allocation status field positions
   localparam int unsigned SCOR_SLOT_CNT_LSB = 16;
   localparam int unsigned SCOR_SLOT_START_LSB = 8;
   localparam int unsigned SCOR_PAYLOAD_ID_LSB = 0;
   localparam int unsigned SCOR_ALLOC_FW = 6;

   // CRC control fields
   localparam int unsigned SCOR_CRC_EN_BIT = 5;
   localparam int unsigned SCOR_CRC_CNT_W = 4;

   // Service interrupt fields
   localparam int unsigned SCOR_SVC_PEND_BIT = 0;
   localparam int unsigned SCOR_SVC_SINK_BIT = 1;
   localparam int unsigned SCOR_SVC_DOWN_BIT = 4;

   // Single-bit flag registers use bit 0
   localparam int unsigned SCOR_FLAG_BIT = 0;
   localparam int unsigned SCOR_BYTE_W = 8;

   // Link rate field and legal codes
   localparam int unsigned SCOR_RATE_W = 5;
   typedef logic [SCOR_RATE_W-1:0] scor_rate_t;
   localparam scor_rate_t SCOR_RATE_1G62 = 5'h06;
   localparam scor_rate_t SCOR_RATE_2G70 = 5'h0A;
   localparam scor_rate_t SCOR_RATE_5G40 = 5'h14;
   localparam scor_rate_t SCOR_RATE_8G10 = 5'h1E;
   localparam scor_rate_t SCOR_RATE_RST = SCOR_RATE_1G62;

   // Reset value and override control enable code
   localparam scor_word_t SCOR_WORD_RST = 32'h0000_0000;
   localparam scor_word_t SCOR_OVR_ENABLE = 32'h0000_0001;
endpackage
`default_nettype wire

// file: rtl/scor_score_select.sv
// Score selector: chooses programmed override or measured training score
`timescale 1ns/1ps
`default_nettype none
module scor_score_select
   import scor_pkg::*;
#(
   parameter int unsigned W = SCOR_TP1_W
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Selection inputs
   input wire logic override_en_in, // Override enable bit from register
   input wire logic [W-1:0] override_val_in, // Programmed score
   input wire logic [W-1:0] measured_in, // Score measured by the receiver
   // Result
   output logic [W-1:0] score_out
);
   logic [W-1:0] score_r;
   logic [W-1:0] score_nxt;

   // Override wins only while its enable bit is set
   always_comb begin
      score_nxt = override_en_in ? override_val_in : measured_in;
   end

   // Register the chosen score so the output is a flop
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         score_r <= '0;
      end else begin
         score_r <= score_nxt;
      end
   end

   assign score_out = score_r;
endmodule
`default_nettype wire

// file: sim/scor_regs_assertions.sv
// Checker: port-level properties of the override register bank
`timescale 1ns/1ps
`default_nettype none
module scor_regs_chk
   import scor_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Host port
   input wire logic [SCOR_AW-1:0] host_addr_in,
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire logic [SCOR_DW-1:0] host_wdata_in,
   input wire logic [SCOR_DW-1:0] host_rdata_out,
   input wire logic host_rvalid_out,
   // Score and mirror signals
   input wire logic [SCOR_TP1_W-1:0] tp1_measured_in,
   input wire logic [SCOR_TP1_W-1:0] tp1_score_out,
   input wire logic [SCOR_ALLOC_FW-1:0] slot_count_in,
   input wire logic [SCOR_ALLOC_FW-1:0] slot_start_in,
   input wire logic sink_specific_interrupt_flag_in,
   input wire logic pending_clear_in,
   input wire logic remote_control_pending_out,
   input wire logic down_reply_ready_out,
   input wire logic video_local_descriptor_flag_out,
   input wire logic [SCOR_BYTE_W-1:0] remote_byte_out,
   input wire logic capability_write_en_out
);
   // Decoded strobes keep the properties short
   logic wr_svc, wr_tp1, rd_alloc;
   assign wr_svc = host_wr_in && host_addr_in == SCOR_OFS_SERVICE_IRQ;
   assign wr_tp1 = host_wr_in && host_addr_in == SCOR_OFS_TP1_SCORE;
   assign rd_alloc = host_rd_in && host_addr_in == SCOR_OFS_PAYLOAD_ALLOC;
   // One clock domain, reset masks everything
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   a_rvalid_pulse: assert property (host_rd_in |=> host_rvalid_out)
      else $error("read answer missing");
   a_pend_set: assert property (wr_svc && host_wdata_in[0] |=> remote_control_pending_out)
      else $error("pending flag not set");
   a_pend_hold: assert property (remote_control_pending_out && !pending_clear_in |=> remote_control_pending_out)
      else $error("pending flag dropped");
   a_down_set: assert property (wr_svc && host_wdata_in[4] |=> down_reply_ready_out)
      else $error("down reply flag not set");
   a_video_desc: assert property (host_wr_in && host_addr_in == SCOR_OFS_VIDEO_DESC |=>
      video_local_descriptor_flag_out == $past(host_wdata_in[0])) else $error("video descriptor flag wrong");
   a_remote_byte: assert property (host_wr_in && host_addr_in == SCOR_OFS_REMOTE_BYTE |=>
      remote_byte_out == $past(host_wdata_in[7:0])) else $error("remote byte wrong");
   a_tp1_override: assert property (wr_tp1 && host_wdata_in[31] ##1 !wr_tp1 |=>
      tp1_score_out == $past(host_wdata_in[14:0], 2)) else $error("override score not used");
   a_tp1_measured: assert property (wr_tp1 && !host_wdata_in[31] ##1 !wr_tp1 |=>
      tp1_score_out == $past(tp1_measured_in)) else $error("measured score not used");
   a_cap_open: assert property (host_wr_in && host_addr_in == SCOR_OFS_OVERRIDE_CTRL |=>
      capability_write_en_out == ($past(host_wdata_in) == SCOR_OVR_ENABLE)) else $error("capability enable wrong");
   a_sink_read: assert property (host_rd_in && host_addr_in == SCOR_OFS_SERVICE_IRQ |=>
      host_rdata_out[1] == $past(sink_specific_interrupt_flag_in)) else $error("sink flag read wrong");
   a_alloc_read: assert property (rd_alloc |=> host_rdata_out[21:16] == $past(slot_count_in) &&
      host_rdata_out[13:8] == $past(slot_start_in)) else $error("allocation read wrong");
   // Main scenarios reached
   c_pend_clear: cover property (remote_control_pending_out ##1 !remote_control_pending_out);
   c_cap_open: cover property ($rose(capability_write_en_out));
   c_tp1_over: cover property (wr_tp1 && host_wdata_in[31]);
endmodule
bind scor_regs scor_regs_chk u_chk (.*);
`default_nettype wire

// file: sim/scor_src_model.sv
// Source transmitter model: polls the service flags and acknowledges them
`timescale 1ns/1ps
`default_nettype none
module scor_src_model
   import scor_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Bench control: low enable leaves flags standing
   input wire logic en_in,
   input wire logic [3:0] wait_in,
   // Flags and byte from the mirror
   input wire logic pend_in,
   input wire logic down_in,
   input wire logic [SCOR_BYTE_W-1:0] byte_in,
   // Acknowledge pulses and captured command
   output logic pend_clr_out,
   output logic down_clr_out,
   output logic [SCOR_BYTE_W-1:0] cmd_out
);
   int cnt;
   logic busy, ack;
   // Poll delay models a slow far end; the count restarts whenever no flag stands
   assign busy = rst_n_in && en_in && (pend_in || down_in);
   assign ack = busy && cnt >= int'(wait_in);
   always @(posedge clk_sys_in) begin
      cnt <= (busy && !ack) ? cnt + 1 : 0;
      // Take the command on the same edge that raises the acknowledge pulse
      cmd_out <= !rst_n_in ? 8'h00 : (ack ? byte_in : cmd_out);
      pend_clr_out <= ack && pend_in;
      down_clr_out <= ack && down_in;
   end
endmodule
`default_nettype wire

// file: sim/scor_regs_tb.sv
// Testbench: host-port sequences against the override register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", n, e, g); end end
module scor_regs_tb
   import scor_pkg::*;
;
   // Clock, reset, host port
   logic clk_sys_in = 1'b0, rst_n_in = 1'b0, host_wr_in = 1'b0, host_rd_in = 1'b0, host_rvalid_out;
   scor_addr_t host_addr_in = 8'h00;
   scor_word_t host_wdata_in = 32'h0000_0000, host_rdata_out, crc_red_out, crc_green_out, crc_blue_out;
   // Receiver levels and far-side signals
   logic [SCOR_TP1_W-1:0] tp1_measured_in = 15'h1111, tp1_score_out;
   logic [SCOR_TP23_W-1:0] tp23_measured_in = 13'h0222, tp23_score_out;
   logic [SCOR_ALLOC_FW-1:0] slot_count_in = 6'h00, slot_start_in = 6'h00, payload_id_in = 6'h00;
   logic sink_specific_interrupt_flag_in = 1'b0, pending_clear_in, down_reply_clear_in, src_en = 1'b0;
   scor_rate_t link_rate_setting_in = SCOR_RATE_2G70, link_rate_setting_out;
   // Mirror outputs
   logic crc_enable_out, video_local_descriptor_flag_out, audio_local_descriptor_flag_out;
   logic remote_control_pending_out, down_reply_ready_out, video_not_supported_out, audio_not_supported_out;
   logic capability_write_en_out;
   logic [SCOR_CRC_CNT_W-1:0] crc_change_count_out;
   logic [SCOR_BYTE_W-1:0] remote_byte_out, last_cmd;
   int failures = 0, compares = 0;
   // Tables: offsets, write values, read-back values (0x6C read-only, 0xF0 unmapped)
   scor_addr_t wa[13] = '{8'h64, 8'h68, 8'h74, 8'h78, 8'h7C, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h94, 8'h98, 8'h6C, 8'hF0};
   scor_word_t wd[13] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_002A, 32'h1234_5678, 32'h9ABC_DEF0,
      32'h0F1E_2D3C, 32'h0000_0001, 32'h0000_0001, 32'h0000_00A5, 32'h0000_0001, 32'h0000_0001,
      32'hFFFF_FFFF, 32'hDEAD_BEEF};
   scor_word_t we[13] = '{32'h8000_7FFF, 32'h8000_1FFF, 32'h0000_002A, 32'h1234_5678, 32'h9ABC_DEF0,
      32'h0F1E_2D3C, 32'h0000_0001, 32'h0000_0001, 32'h0000_00A5, 32'h0000_0001, 32'h0000_0001,
      32'h002A_153F, 32'h0000_0000};
   scor_rate_t rates[4] = '{SCOR_RATE_8G10, SCOR_RATE_5G40, SCOR_RATE_1G62, SCOR_RATE_2G70};

   // Free-running 10 MHz clock
   always #50 clk_sys_in = ~clk_sys_in;

   scor_regs dut (.*);
   // Far end acknowledging service flags after a short poll delay
   scor_src_model u_src (.clk_sys_in, .rst_n_in, .en_in(src_en), .wait_in(4'h3),
      .pend_in(remote_control_pending_out), .down_in(down_reply_ready_out), .byte_in(remote_byte_out),
      .pend_clr_out(pending_clear_in), .down_clr_out(down_reply_clear_in), .cmd_out(last_cmd));

   // Bus tasks: entered 1 ns after an edge, strobe held for exactly one edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic wr(input scor_addr_t a, input scor_word_t d);
      host_addr_in = a;
      host_wdata_in = d;
      host_wr_in = 1'b1;
      tick(1);
      host_wr_in = 1'b0;
      tick(1);
   endtask
   task automatic rd(input scor_addr_t a, input scor_word_t e);
      host_addr_in = a;
      host_rd_in = 1'b1;
      tick(1);
      host_rd_in = 1'b0;
      `CHK("rvalid", 1'b1, host_rvalid_out)
      `CHK($sformatf("rdata %h", a), e, host_rdata_out)
      tick(1);
   endtask
   // Verdict and end of run
   task automatic results();
      if (failures == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog well beyond the roughly 150 cycles the tests need
   initial begin
      repeat (3000) @(posedge clk_sys_in);
      failures++;
      results();
   end

   initial begin
      tick(12);
      rst_n_in = 1'b1;
      tick(1);
      // Reset read-back of each register except allocation, service and override control
      for (int i = 0; i < 11; i++) rd(wa[i], 32'h0000_0000);
      rd(SCOR_OFS_LINK_RATE, {27'h000_0000, SCOR_RATE_RST});
      // Full write then read-back, including read-only and unmapped places
      {slot_count_in, slot_start_in, payload_id_in} = {6'h2A, 6'h15, 6'h3F};
      for (int i = 0; i < 13; i++) wr(wa[i], wd[i]);
      for (int i = 0; i < 13; i++) rd(wa[i], we[i]);
      `CHK("crc_en", 1'b1, crc_enable_out)
      `CHK("crc_cnt", 4'hA, crc_change_count_out)
      `CHK("crc_blue", 32'h0F1E_2D3C, crc_blue_out)
      `CHK("crc_red", 32'h1234_5678, crc_red_out)
      `CHK("crc_green", 32'h9ABC_DEF0, crc_green_out)
      `CHK("vdesc", 1'b1, video_local_descriptor_flag_out)
      `CHK("adesc", 1'b1, audio_local_descriptor_flag_out)
      `CHK("remote", 8'hA5, remote_byte_out)
      `CHK("vunsup", 1'b1, video_not_supported_out)
      `CHK("aunsup", 1'b1, audio_not_supported_out)
      `CHK("tp1", 15'h7FFF, tp1_score_out)
      `CHK("tp23", 13'h1FFF, tp23_score_out)
      // Clearing the enables falls back to measured scores
      wr(SCOR_OFS_TP1_SCORE, 32'h0000_0123);
      wr(SCOR_OFS_TP23_SCORE, 32'h0000_0ABC);
      tick(2);
      `CHK("tp1", 15'h1111, tp1_score_out)
      `CHK("tp23", 13'h0222, tp23_score_out)
      // Service flags: zero write, set, second zero write, live read
      sink_specific_interrupt_flag_in = 1'b1;
      wr(SCOR_OFS_SERVICE_IRQ, 32'h0000_0000);
      `CHK("pending", 1'b0, remote_control_pending_out)
      wr(SCOR_OFS_SERVICE_IRQ, 32'h0000_0011);
      wr(SCOR_OFS_SERVICE_IRQ, 32'h0000_0000);
      `CHK("pending", 1'b1, remote_control_pending_out)
      `CHK("down", 1'b1, down_reply_ready_out)
      rd(SCOR_OFS_SERVICE_IRQ, 32'h0000_0013);
      src_en = 1'b1;
      tick(12);
      `CHK("pending", 1'b0, remote_control_pending_out)
      `CHK("down", 1'b0, down_reply_ready_out)
      `CHK("cmd", 8'hA5, last_cmd)
      sink_specific_interrupt_flag_in = 1'b0;
      rd(SCOR_OFS_SERVICE_IRQ, 32'h0000_0000);
      // Link rate: ignored while closed, applied per legal code once opened
      wr(SCOR_OFS_LINK_RATE, {27'h000_0000, SCOR_RATE_5G40});
      tick(2);
      `CHK("rate", SCOR_RATE_2G70, link_rate_setting_out)
      wr(SCOR_OFS_OVERRIDE_CTRL, SCOR_OVR_ENABLE);
      for (int i = 0; i < 4; i++) begin
         wr(SCOR_OFS_LINK_RATE, {27'h000_0000, rates[i]});
         tick(2);
         `CHK("rate", rates[i], link_rate_setting_out)
      end
      `CHK("cap_en", 1'b1, capability_write_en_out)
      wr(SCOR_OFS_LINK_RATE, 32'h0000_0007);
      tick(2);
      `CHK("rate", SCOR_RATE_2G70, link_rate_setting_out)
      rd(SCOR_OFS_LINK_RATE, 32'h0000_0007);
      wr(SCOR_OFS_OVERRIDE_CTRL, 32'h0000_0002);
      `CHK("cap_en", 1'b0, capability_write_en_out)
      // Mid-run reset clears the mirror
      rst_n_in = 1'b0;
      tick(2);
      rst_n_in = 1'b1;
      tick(1);
      `CHK("remote", 8'h00, remote_byte_out)
      `CHK("crc_en", 1'b0, crc_enable_out)
      results();
   end
endmodule
`default_nettype wire
